// ---- src/cdm_pkg.sv ----
/*
 * Shared constants and types of the controller data memory: area
 * selectors, word and bit limits, write masks and fixed timer numbers.
 * Assumes word and bit addresses arrive as four binary-coded digits.
 */

package cdm_pkg;

    // word and digit geometry
    localparam int CDM_WORD_BITS = 16;
    localparam int CDM_DIGITS = 4;
    localparam int CDM_INPUT_BITS = 12;
    localparam int CDM_OUTPUT_BITS = 8;

    // area sizes
    localparam int CDM_PLAIN_WORDS = 21;
    localparam int CDM_RETAINED_WORDS = 16;
    localparam int CDM_TC_NUMBERS = 16;

    // address limits as binary values of the decoded digit pairs
    localparam logic [6:0] CDM_LAST_PLAIN_WORD = 7'h14;
    localparam logic [6:0] CDM_LAST_AREA_WORD = 7'h0F;
    localparam logic [6:0] CDM_LAST_BIT = 7'h0F;
    localparam logic [6:0] CDM_BCD_TEN = 7'h0A;
    localparam logic [3:0] CDM_BCD_MAX = 4'h9;

    // fixed plain word positions
    localparam logic [4:0] CDM_WORD_INPUT = 5'h00;
    localparam logic [4:0] CDM_WORD_OUTPUT = 5'h01;
    localparam logic [4:0] CDM_WORD_LINK_TX = 5'h13;
    localparam logic [4:0] CDM_WORD_LINK_RX = 5'h14;

    // writable bits per word
    localparam logic [15:0] CDM_INPUT_WORD_MASK = 16'hF000;
    localparam logic [15:0] CDM_FULL_MASK = 16'hFFFF;
    localparam logic [15:0] CDM_NO_MASK = 16'h0000;
    localparam logic [15:0] CDM_WORD_RESET = 16'h0000;

    // timer/counter numbers tied to fixed instructions
    localparam logic [3:0] CDM_TC_ANALOG_TIMER_ONE = 4'hB;
    localparam logic [3:0] CDM_TC_ANALOG_TIMER_TWO = 4'hC;
    localparam logic [3:0] CDM_TC_HIGH_SPEED_TIMER = 4'hE;
    localparam logic [3:0] CDM_TC_ANALOG_TIMER = 4'hF;

    // explicit area selector carried with every operand
    typedef enum logic [1:0] {
        CDM_AREA_PLAIN = 2'h0,
        CDM_AREA_RETAINED = 2'h1,
        CDM_AREA_TIMER = 2'h2,
        CDM_AREA_NONE = 2'h3
    } cdm_area_t;

    // decoded operand
    typedef struct packed {
        logic ok;
        logic [4:0] word;
        logic [3:0] bitn;
    } cdm_dec_t;

endpackage

// ---- src/cdm_digit_check.sv ----
/*
 * Flags every four-bit digit of a value that is not a decimal digit.
 * Assumes the caller decides whether the value is meant as decimal.
 */

`timescale 1ns/1ns
`default_nettype none

module cdm_digit_check #(
    parameter int DIGITS = 4
) (
    input wire logic [4*DIGITS-1:0] value_i,
    output logic [DIGITS-1:0] bad_o
);
    import cdm_pkg::*;

    if (DIGITS < 1) begin : g_check
        $error("cdm_digit_check needs at least one digit");
    end

    // one comparator per digit, digit 0 rightmost
    for (genvar g = 0; g < DIGITS; g++) begin : g_digit
        assign bad_o[g] = value_i[4*g +: 4] > CDM_BCD_MAX;
    end

endmodule

`default_nettype wire

// ---- src/cdm_data_memory.sv ----
/*
 * Data memory and operand decoder of a small programmable controller:
 * input, output, work, link exchange, dedicated, retained and
 * timer/counter areas behind one read port and one write port.
 * Assumes the execution unit shares clock_i, drives pass_end_i once
 * per program pass, and that the link logic is synchronous to clock_i.
 */
// Notes on behaviour
// - word 00 bits 0-11 are sampled inputs
// - word 01 bits 0-7 drive outputs
// - last write in a pass reaches terminal
// - work bits in words 00-02, 10-18
// - word 19 sent, word 20 received on link
// - without link words 19, 20 are work
// - words 03-09 hold dedicated bits
// - retained words survive reset and power loss
// - sixteen timer numbers, four fixed to timers
// - addresses outside areas are refused
// - words are 16 bits, bit 00 rightmost
// - bit address is word digits plus bit digits
// - bit digits above 15 are refused
// - timer word is value, bit is flag
// - decimal words stored BCD, hex binary
// - four digits per word, 0 rightmost
// - retained and timer areas need selector
// - BCD digits above 9 are invalid
// - pass end copies outputs, samples inputs

`timescale 1ns/1ns
`default_nettype none

module cdm_data_memory #(
    parameter int HAS_LINK = 1
) (
    input wire logic clock_i,
    input wire logic reset_i,
    // end of program pass
    input wire logic pass_end_i,
    // terminals and link words
    input wire logic [cdm_pkg::CDM_INPUT_BITS-1:0] input_pins_i,
    output logic [cdm_pkg::CDM_OUTPUT_BITS-1:0] output_pins_o,
    input wire logic [15:0] link_rx_word_i,
    output logic [15:0] link_tx_word_o,
    // read port
    input wire logic rd_req_i,
    input wire cdm_pkg::cdm_area_t rd_area_i,
    input wire logic rd_is_bit_i,
    input wire logic [15:0] rd_addr_i,
    input wire logic [1:0] rd_digit_sel_i,
    output logic rd_valid_o,
    output logic rd_invalid_o,
    output logic [15:0] rd_data_o,
    output logic rd_bit_o,
    output logic [3:0] rd_digit_o,
    // write port
    input wire logic wr_req_i,
    input wire cdm_pkg::cdm_area_t wr_area_i,
    input wire logic wr_is_bit_i,
    input wire logic [15:0] wr_addr_i,
    input wire logic [15:0] wr_data_i,
    input wire logic wr_bit_i,
    input wire logic wr_decimal_i,
    output logic wr_invalid_o,
    // completion flags of the fixed timers, 11, 12, 14, 15
    output logic [3:0] tc_fixed_flags_o
);
    import cdm_pkg::*;

    if (HAS_LINK != 0 && HAS_LINK != 1) begin : g_check
        $error("HAS_LINK must be 0 or 1");
    end

    ////////////////////////////////////////////////////////////////////
    // storage

    logic [15:0] mem_q [0:CDM_PLAIN_WORDS-1];
    logic [15:0] ret_q [0:CDM_RETAINED_WORDS-1];
    logic [15:0] pv_q [0:CDM_TC_NUMBERS-1];
    logic [CDM_TC_NUMBERS-1:0] flag_q;
    logic [CDM_INPUT_BITS-1:0] in_s1_q, in_s2_q, in_s3_q, in_stable_q;
    logic [CDM_OUTPUT_BITS-1:0] out_q;
    logic [15:0] link_tx_q;
    logic rd_valid_q, rd_invalid_q, rd_bit_q, wr_invalid_q;
    logic [15:0] rd_data_q;
    logic [3:0] rd_digit_q;

    // decode results
    logic [3:0] rd_addr_bad, wr_addr_bad, wr_data_bad;
    cdm_dec_t rd_dec, wr_dec;
    logic [15:0] rd_word_sel, wr_old, wr_new, wr_mask;
    logic rd_bit_sel, wr_ok, wr_bcd_bad;

    ////////////////////////////////////////////////////////////////////
    // helpers

    // two decimal digits to a binary number
    function automatic logic [6:0] bcd2(input logic [3:0] hi,
                                        input logic [3:0] lo);
        logic [6:0] h;
        h = {3'h0, hi};
        return 7'(h * CDM_BCD_TEN) + {3'h0, lo};
    endfunction

    // operand decode: four digits, area selector, bit or word use
    function automatic cdm_dec_t dec_op(input cdm_area_t area,
                                        input logic is_bit,
                                        input logic [15:0] a,
                                        input logic [3:0] bad);
        cdm_dec_t r;
        logic [6:0] hi, lo, limit;
        hi = bcd2(a[15:12], a[11:8]);
        lo = bcd2(a[7:4], a[3:0]);
        limit = (area == CDM_AREA_PLAIN) ? CDM_LAST_PLAIN_WORD
                                         : CDM_LAST_AREA_WORD;
        r.ok = (bad == 4'h0);
        if (is_bit && area != CDM_AREA_TIMER) begin
            // word digits high, bit digits low
            r.word = hi[4:0];
            r.bitn = lo[3:0];
            r.ok = r.ok && (lo <= CDM_LAST_BIT) && (hi <= limit);
        end else begin
            // word operand or timer number in the low digits
            r.word = lo[4:0];
            r.bitn = 4'h0;
            r.ok = r.ok && (hi == 7'h00) && (lo <= limit);
        end
        if (area == CDM_AREA_NONE) begin
            r.ok = 1'b0;
        end
        return r;
    endfunction

    // bits of a plain word that the program may write
    function automatic logic [15:0] plain_mask(input logic [4:0] w);
        logic [15:0] m;
        m = CDM_FULL_MASK;
        if (w == CDM_WORD_INPUT) begin
            m = CDM_INPUT_WORD_MASK;
        end else if (w == CDM_WORD_LINK_RX && HAS_LINK == 1) begin
            m = CDM_NO_MASK;
        end
        return m;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // digit checks on both addresses and on decimal write data

    cdm_digit_check #(.DIGITS(CDM_DIGITS)) u_rd_addr_check (
        .value_i(rd_addr_i),
        .bad_o(rd_addr_bad)
    );

    cdm_digit_check #(.DIGITS(CDM_DIGITS)) u_wr_addr_check (
        .value_i(wr_addr_i),
        .bad_o(wr_addr_bad)
    );

    cdm_digit_check #(.DIGITS(CDM_DIGITS)) u_wr_data_check (
        .value_i(wr_data_i),
        .bad_o(wr_data_bad)
    );

    ////////////////////////////////////////////////////////////////////
    // input terminal synchroniser

    // three stages; the first is only read by the second
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            in_s1_q <= '0;
            in_s2_q <= '0;
            in_s3_q <= '0;
        end else begin
            in_s1_q <= input_pins_i;
            in_s2_q <= in_s1_q;
            in_s3_q <= in_s2_q;
        end
    end

    // a bit changes only where stages two and three agree
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            in_stable_q <= '0;
        end else begin
            in_stable_q <= (in_s3_q & ~(in_s2_q ^ in_s3_q))
                         | (in_stable_q & (in_s2_q ^ in_s3_q));
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read port

    assign rd_dec = dec_op(rd_area_i, rd_is_bit_i, rd_addr_i, rd_addr_bad);

    // word and bit selected by the read operand
    always_comb begin
        rd_word_sel = CDM_WORD_RESET;
        case (rd_area_i)
            CDM_AREA_PLAIN: rd_word_sel = mem_q[rd_dec.word];
            CDM_AREA_RETAINED: rd_word_sel = ret_q[rd_dec.word[3:0]];
            CDM_AREA_TIMER: rd_word_sel = pv_q[rd_dec.word[3:0]];
            CDM_AREA_NONE: rd_word_sel = CDM_WORD_RESET;
        endcase
        if (rd_area_i == CDM_AREA_TIMER) begin
            rd_bit_sel = flag_q[rd_dec.word[3:0]];
        end else begin
            rd_bit_sel = rd_word_sel[rd_dec.bitn];
        end
    end

    // registered answer one cycle after the request
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            rd_valid_q <= 1'b0;
            rd_invalid_q <= 1'b0;
            rd_data_q <= CDM_WORD_RESET;
            rd_bit_q <= 1'b0;
            rd_digit_q <= 4'h0;
        end else begin
            rd_valid_q <= rd_req_i;
            if (rd_req_i) begin
                rd_invalid_q <= !rd_dec.ok;
                rd_data_q <= (rd_dec.ok && !rd_is_bit_i) ? rd_word_sel
                                                         : CDM_WORD_RESET;
                rd_bit_q <= rd_dec.ok && rd_is_bit_i && rd_bit_sel;
                if (rd_dec.ok && !rd_is_bit_i) begin
                    rd_digit_q <= rd_word_sel[{rd_digit_sel_i, 2'h0} +: 4];
                end else begin
                    rd_digit_q <= 4'h0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // write port

    assign wr_dec = dec_op(wr_area_i, wr_is_bit_i, wr_addr_i, wr_addr_bad);
    assign wr_mask = (wr_area_i == CDM_AREA_PLAIN) ? plain_mask(wr_dec.word)
                                                   : CDM_FULL_MASK;
    // decimal word data must be valid BCD; hex data is taken as is
    assign wr_bcd_bad = wr_decimal_i && !wr_is_bit_i
                     && (wr_data_bad != 4'h0);
    assign wr_ok = wr_req_i && wr_dec.ok && !wr_bcd_bad
                && (wr_is_bit_i ? wr_mask[wr_dec.bitn]
                                : (wr_mask != CDM_NO_MASK));

    // merged word: one bit replaced, or masked word
    always_comb begin
        wr_old = CDM_WORD_RESET;
        case (wr_area_i)
            CDM_AREA_PLAIN: wr_old = mem_q[wr_dec.word];
            CDM_AREA_RETAINED: wr_old = ret_q[wr_dec.word[3:0]];
            CDM_AREA_TIMER: wr_old = pv_q[wr_dec.word[3:0]];
            CDM_AREA_NONE: wr_old = CDM_WORD_RESET;
        endcase
        wr_new = (wr_old & ~wr_mask) | (wr_data_i & wr_mask);
        if (wr_is_bit_i) begin
            wr_new = wr_old;
            wr_new[wr_dec.bitn] = wr_bit_i;
        end
    end

    // refused write answered one cycle later
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            wr_invalid_q <= 1'b0;
        end else begin
            wr_invalid_q <= wr_req_i && !wr_ok;
        end
    end

    // plain words: writes, then pass-end input and link sampling
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            for (int i = 0; i < CDM_PLAIN_WORDS; i++) begin
                mem_q[i] <= CDM_WORD_RESET;
            end
        end else begin
            if (wr_ok && wr_area_i == CDM_AREA_PLAIN) begin
                mem_q[wr_dec.word] <= wr_new;
            end
            if (pass_end_i) begin
                mem_q[CDM_WORD_INPUT][CDM_INPUT_BITS-1:0] <= in_stable_q;
                if (HAS_LINK == 1) begin
                    mem_q[CDM_WORD_LINK_RX] <= link_rx_word_i;
                end
            end
        end
    end

    // retained words carry no reset so their content survives it
    always_ff @(posedge clock_i) begin
        if (wr_ok && wr_area_i == CDM_AREA_RETAINED) begin
            ret_q[wr_dec.word[3:0]] <= wr_new;
        end
    end

    // timer numbers: word writes go to the value, bit writes to the flag
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            for (int i = 0; i < CDM_TC_NUMBERS; i++) begin
                pv_q[i] <= CDM_WORD_RESET;
            end
            flag_q <= '0;
        end else if (wr_ok && wr_area_i == CDM_AREA_TIMER) begin
            if (wr_is_bit_i) begin
                flag_q[wr_dec.word[3:0]] <= wr_bit_i;
            end else begin
                pv_q[wr_dec.word[3:0]] <= wr_data_i;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // terminals and link words, refreshed once per pass

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            out_q <= '0;
            link_tx_q <= CDM_WORD_RESET;
        end else if (pass_end_i) begin
            out_q <= mem_q[CDM_WORD_OUTPUT][CDM_OUTPUT_BITS-1:0];
            link_tx_q <= (HAS_LINK == 1) ? mem_q[CDM_WORD_LINK_TX]
                                         : CDM_WORD_RESET;
        end
    end

    // outputs
    assign output_pins_o = out_q;
    assign link_tx_word_o = link_tx_q;
    assign rd_valid_o = rd_valid_q;
    assign rd_invalid_o = rd_invalid_q;
    assign rd_data_o = rd_data_q;
    assign rd_bit_o = rd_bit_q;
    assign rd_digit_o = rd_digit_q;
    assign wr_invalid_o = wr_invalid_q;
    assign tc_fixed_flags_o = {flag_q[CDM_TC_ANALOG_TIMER],
                               flag_q[CDM_TC_HIGH_SPEED_TIMER],
                               flag_q[CDM_TC_ANALOG_TIMER_TWO],
                               flag_q[CDM_TC_ANALOG_TIMER_ONE]};

    ////////////////////////////////////////////////////////////////////
    // checks

    input_image_a: assert property (
        @(posedge clock_i) disable iff (reset_i)
        pass_end_i |=> mem_q[CDM_WORD_INPUT][CDM_INPUT_BITS-1:0]
                       == $past(in_stable_q))
        else $error("input bits not sampled at pass end");

    output_copy_a: assert property (
        @(posedge clock_i) disable iff (reset_i)
        pass_end_i |=> output_pins_o
                       == $past(mem_q[CDM_WORD_OUTPUT][7:0]))
        else $error("output terminals not copied at pass end");

    output_hold_a: assert property (
        @(posedge clock_i) disable iff (reset_i)
        !pass_end_i |=> $stable(output_pins_o))
        else $error("output terminals moved inside a pass");

    last_write_a: assert property (
        @(posedge clock_i) disable iff (reset_i)
        (wr_ok && wr_area_i == CDM_AREA_PLAIN && wr_is_bit_i
         && wr_dec.word == CDM_WORD_OUTPUT && !wr_dec.bitn[3])
        ##1 !wr_req_i ##1 (pass_end_i && !wr_req_i)
        |=> output_pins_o[$past(wr_dec.bitn[2:0], 3)] == $past(wr_bit_i, 3))
        else $error("last output write did not reach terminal");

    bit_number_a: assert property (
        @(posedge clock_i) disable iff (reset_i)
        (rd_req_i && rd_is_bit_i && rd_area_i != CDM_AREA_TIMER
         && rd_addr_i[7:4] == 4'h1 && rd_addr_i[3:0] > 4'h5)
        |=> rd_valid_o && rd_invalid_o)
        else $error("bit number above 15 accepted");

    word_range_a: assert property (
        @(posedge clock_i) disable iff (reset_i)
        (rd_req_i && !rd_is_bit_i && rd_area_i == CDM_AREA_PLAIN
         && rd_addr_i[15:4] == 12'h002 && rd_addr_i[3:0] != 4'h0)
        |=> rd_invalid_o && rd_data_o == 16'h0000)
        else $error("word beyond 20 accepted");

    read_answer_a: assert property (
        @(posedge clock_i) disable iff (reset_i)
        rd_req_i |=> rd_valid_o && (rd_invalid_o == !$past(rd_dec.ok)))
        else $error("read answer or invalid flag wrong");

    bcd_reject_a: assert property (
        @(posedge clock_i) disable iff (reset_i)
        (wr_req_i && wr_decimal_i && !wr_is_bit_i
         && wr_data_i[15:12] > 4'h9) |=> wr_invalid_o)
        else $error("bad decimal digit accepted");

    input_write_a: assert property (
        @(posedge clock_i) disable iff (reset_i)
        (wr_req_i && wr_is_bit_i && wr_area_i == CDM_AREA_PLAIN
         && wr_addr_i[15:4] == 12'h000) |=> wr_invalid_o)
        else $error("write to an input bit accepted");

    retained_keep_a: assert property (
        @(posedge clock_i) disable iff (reset_i)
        (wr_ok && wr_area_i == CDM_AREA_RETAINED && !wr_is_bit_i)
        |=> ret_q[$past(wr_dec.word[3:0])] == $past(wr_data_i))
        else $error("retained word not stored");

    link_tx_a: assert property (
        @(posedge clock_i) disable iff (reset_i)
        pass_end_i |=> link_tx_word_o == ((HAS_LINK == 1)
                       ? $past(mem_q[CDM_WORD_LINK_TX]) : 16'h0000))
        else $error("link transmit word wrong");

endmodule

`default_nettype wire

// ---- tb/cdm_exec_model.sv ----
/*
 * Execution unit model: issues one read or one write operand per call.
 * Assumes the caller waits for the first clock edge after reset release.
 */

`timescale 1ns/1ns
`default_nettype none

module cdm_exec_model (
    input wire logic clock_i,
    output logic rd_req_o,
    output var cdm_pkg::cdm_area_t rd_area_o,
    output logic rd_is_bit_o,
    output logic [15:0] rd_addr_o,
    output logic [1:0] rd_sel_o,
    output logic wr_req_o,
    output var cdm_pkg::cdm_area_t wr_area_o,
    output logic wr_is_bit_o,
    output logic [15:0] wr_addr_o,
    output logic [15:0] wr_data_o,
    output logic wr_bit_o,
    output logic wr_dec_o
);
    import cdm_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // idle bus at time zero
    initial begin
        rd_req_o = 1'b0;
        rd_area_o = CDM_AREA_NONE;
        rd_is_bit_o = 1'b0;
        rd_addr_o = 16'hFFFF;
        rd_sel_o = 2'h0;
        wr_req_o = 1'b0;
        wr_area_o = CDM_AREA_NONE;
        wr_is_bit_o = 1'b0;
        wr_addr_o = 16'hFFFF;
        wr_data_o = 16'h0000;
        wr_bit_o = 1'b0;
        wr_dec_o = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // one read, held for the taking edge, address scrambled when released
    task automatic rd_op(input cdm_area_t a, input logic b,
                         input logic [15:0] ad, input logic [1:0] s);
        @(posedge clock_i);
        rd_req_o <= 1'b1;
        rd_area_o <= a;
        rd_is_bit_o <= b;
        rd_addr_o <= ad;
        rd_sel_o <= s;
        @(posedge clock_i);
        rd_req_o <= 1'b0;
        rd_addr_o <= ~ad;
    endtask

    // one write, data scrambled when released
    task automatic wr_op(input cdm_area_t a, input logic b,
                         input logic [15:0] ad, input logic [15:0] d,
                         input logic v, input logic dec);
        @(posedge clock_i);
        wr_req_o <= 1'b1;
        wr_area_o <= a;
        wr_is_bit_o <= b;
        wr_addr_o <= ad;
        wr_data_o <= d;
        wr_bit_o <= v;
        wr_dec_o <= dec;
        @(posedge clock_i);
        wr_req_o <= 1'b0;
        wr_data_o <= ~d;
        wr_bit_o <= ~v;
    endtask
endmodule

`default_nettype wire

// ---- tb/cdm_data_memory_test.sv ----
/*
 * Self-checking bench of the data memory: expectations queued by the
 * driver, answers compared by a watcher. Assumes the link variant.
 */

`timescale 1ns/1ns
`default_nettype none

module cdm_data_memory_test;
    import cdm_pkg::*;
    typedef struct packed {
        logic inv;
        logic [15:0] data;
        logic b;
        logic [3:0] dig;
    } cdm_rexp_t;
    localparam cdm_area_t AP = CDM_AREA_PLAIN;
    localparam cdm_area_t AR = CDM_AREA_RETAINED;
    localparam cdm_area_t AT = CDM_AREA_TIMER;
    localparam cdm_area_t AN = CDM_AREA_NONE;
    logic clock_i = 1'b0;
    logic reset_i = 1'b1;
    logic pass_end = 1'b0;
    logic [11:0] pins = 12'h000;
    logic [15:0] rx = 16'h0000;
    logic rd_req, rd_is_bit, rd_valid, rd_invalid, rd_bit;
    logic wr_req, wr_is_bit, wr_bit, wr_dec, wr_invalid;
    logic [1:0] rd_sel;
    logic [3:0] rd_digit, tc_flags;
    logic [7:0] out_pins;
    logic [15:0] rd_addr, rd_data, wr_addr, wr_data, tx, v;
    cdm_area_t rd_area, wr_area;
    logic wr_d1 = 1'b0;
    cdm_rexp_t rq[$];
    cdm_rexp_t e;
    logic wq[$];
    int fails = 0;
    int checked = 0;
    int seed = 32'hEFED;
    logic [18:0] bad[6] = '{{AP, 17'h10216}, {AP, 17'h00021},
        {AR, 17'h00016}, {AP, 17'h10A00}, {AN, 17'h00002}, {AT, 17'h00016}};

    always #25 clock_i = ~clock_i;

    cdm_data_memory #(.HAS_LINK(1)) DUT (.clock_i(clock_i), .reset_i(reset_i),
        .pass_end_i(pass_end), .input_pins_i(pins), .output_pins_o(out_pins),
        .link_rx_word_i(rx), .link_tx_word_o(tx), .rd_req_i(rd_req),
        .rd_area_i(rd_area), .rd_is_bit_i(rd_is_bit), .rd_addr_i(rd_addr),
        .rd_digit_sel_i(rd_sel), .rd_valid_o(rd_valid),
        .rd_invalid_o(rd_invalid), .rd_data_o(rd_data), .rd_bit_o(rd_bit),
        .rd_digit_o(rd_digit), .wr_req_i(wr_req), .wr_area_i(wr_area),
        .wr_is_bit_i(wr_is_bit), .wr_addr_i(wr_addr), .wr_data_i(wr_data),
        .wr_bit_i(wr_bit), .wr_decimal_i(wr_dec), .wr_invalid_o(wr_invalid),
        .tc_fixed_flags_o(tc_flags));

    cdm_exec_model eu (.clock_i(clock_i), .rd_req_o(rd_req),
        .rd_area_o(rd_area), .rd_is_bit_o(rd_is_bit), .rd_addr_o(rd_addr),
        .rd_sel_o(rd_sel), .wr_req_o(wr_req), .wr_area_o(wr_area),
        .wr_is_bit_o(wr_is_bit), .wr_addr_o(wr_addr), .wr_data_o(wr_data),
        .wr_bit_o(wr_bit), .wr_dec_o(wr_dec));

    ////////////////////////////////////////////////////////////////////////
    // compare, verdict and helpers
    task automatic chk(input string n, input logic [15:0] x,
                       input logic [15:0] g);
        checked++;
        if (g !== x) begin
            fails++;
            $display("wrong value %s expected %h seen %h", n, x, g);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    function automatic logic [15:0] bcd(input int n);
        return {8'h00, 4'(n / 10), 4'(n % 10)};
    endfunction

    // queue the answer, then hand the read to the execution model
    task automatic rd(input cdm_area_t a, input logic b, input logic [15:0] ad,
                      input logic [1:0] s, input logic i,
                      input logic [15:0] d, input logic bv);
        rq.push_back({i, b ? 16'h0 : d, b & bv, (b | i) ? 4'h0 : d[s*4+:4]});
        eu.rd_op(a, b, ad, s);
    endtask

    task automatic wr(input cdm_area_t a, input logic b, input logic [15:0] ad,
                      input logic [15:0] d, input logic bv, input logic dec,
                      input logic i);
        wq.push_back(i);
        eu.wr_op(a, b, ad, d, bv, dec);
    endtask

    task automatic pass();
        @(posedge clock_i);
        pass_end <= 1'b1;
        @(posedge clock_i);
        pass_end <= 1'b0;
        @(negedge clock_i);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // watcher: takes the oldest note whenever an answer is due
    always @(posedge clock_i) begin
        wr_d1 <= wr_req;
    end

    always @(negedge clock_i) begin
        if (wr_d1 === 1'b1 && wq.size() > 0) begin
            chk("wr_invalid", 16'(wq.pop_front()), 16'(wr_invalid));
        end else if (wr_invalid !== 1'b0) begin
            chk("wr_invalid", 16'h0, 16'(wr_invalid));
        end
        if (rd_valid === 1'b1 && rq.size() > 0) begin
            e = rq.pop_front();
            chk("rd_invalid", 16'(e.inv), 16'(rd_invalid));
            chk("rd_data", e.data, rd_data);
            chk("rd_bit", 16'(e.b), 16'(rd_bit));
            chk("rd_digit", 16'(e.dig), 16'(rd_digit));
        end else if (rd_valid !== 1'b0) begin
            chk("rd_valid", 16'h0, 16'(rd_valid));
        end
    end

    // watchdog against a hang
    initial begin
        #400000;
        fails++;
        test_done();
    end

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (6) @(posedge clock_i);
        reset_i <= 1'b0;
        @(negedge clock_i);
        chk("output_pins", 16'h0, 16'(out_pins));
        chk("link_tx", 16'h0, tx);
        wr(AP, 1, 16'h0100, 0, 1, 0, 0);
        wr(AP, 1, 16'h0100, 0, 0, 0, 0);
        wr(AP, 1, 16'h0100, 0, 1, 0, 0);
        wr(AP, 1, 16'h0103, 0, 1, 0, 0);
        @(negedge clock_i);
        chk("output_pins", 16'h0, 16'(out_pins));
        pass();
        chk("output_pins", 16'h09, 16'(out_pins));
        rd(AP, 0, 16'h0001, 2'h0, 0, 16'h0009, 0);
        rd(AP, 1, 16'h0103, 2'h0, 0, 0, 1);
        $display("test outputs done");
        for (int w = 2; w <= 18; w++) begin
            v = 16'($random(seed));
            wr(AP, 0, bcd(w), v, 0, 0, 0);
            rd(AP, 0, bcd(w), 2'(w), 0, v, 0);
        end
        $display("test words done");
        pins <= 12'($random(seed));
        rx <= 16'($random(seed));
        v = 16'($random(seed));
        wr(AP, 1, 16'h0005, 0, 1, 0, 1);
        wr(AP, 1, 16'h0012, 0, 1, 0, 0);
        wr(AP, 0, 16'h0019, v, 0, 0, 0);
        wr(AP, 0, 16'h0020, v, 0, 0, 1);
        repeat (5) @(posedge clock_i);
        pass();
        chk("link_tx", v, tx);
        rd(AP, 0, 16'h0000, 2'h3, 0, {4'h1, pins}, 0);
        rd(AP, 0, 16'h0020, 2'h1, 0, rx, 0);
        $display("test pass end done");
        wr(AP, 0, 16'h0002, 16'h1234, 0, 1, 0);
        wr(AP, 0, 16'h0002, 16'hA2A4, 0, 1, 1);
        rd(AP, 0, 16'h0002, 2'h2, 0, 16'h1234, 0);
        wr(AP, 0, 16'h0002, 16'h12A4, 0, 0, 0);
        rd(AP, 0, 16'h0002, 2'h1, 0, 16'h12A4, 0);
        $display("test decimal done");
        for (int i = 0; i < 6; i++) begin
            wr(cdm_area_t'(bad[i][18:17]), bad[i][16], bad[i][15:0],
               16'h0001, 1, 0, 1);
            rd(cdm_area_t'(bad[i][18:17]), bad[i][16], bad[i][15:0],
               2'h0, 1, 0, 0);
        end
        $display("test invalid done");
        v = 16'($random(seed));
        wr(AR, 0, 16'h0005, v, 0, 0, 0);
        rd(AR, 1, 16'h0513, 2'h0, 0, 0, v[13]);
        @(posedge clock_i);
        reset_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        reset_i <= 1'b0;
        @(negedge clock_i);
        chk("output_pins", 16'h0, 16'(out_pins));
        rd(AR, 0, 16'h0005, 2'h3, 0, v, 0);
        rd(AP, 0, 16'h0002, 2'h0, 0, 16'h0000, 0);
        $display("test retained done");
        wr(AT, 0, 16'h0003, 16'h0123, 0, 1, 0);
        wr(AT, 1, 16'h0003, 0, 1, 0, 0);
        rd(AT, 0, 16'h0003, 2'h1, 0, 16'h0123, 0);
        rd(AT, 1, 16'h0003, 2'h0, 0, 0, 1);
        wr(AT, 1, bcd(11), 0, 1, 0, 0);
        wr(AT, 1, bcd(12), 0, 1, 0, 0);
        wr(AT, 1, bcd(15), 0, 1, 0, 0);
        @(negedge clock_i);
        chk("tc_flags", 16'hB, 16'(tc_flags));
        wr(AT, 1, bcd(14), 0, 1, 0, 0);
        @(negedge clock_i);
        chk("tc_flags", 16'hF, 16'(tc_flags));
        $display("test timers done");
        repeat (4) @(posedge clock_i);
        test_done();
    end
endmodule

`default_nettype wire
